// File: bench/fosr_cpu_model.sv
/*
 * cpu read model for the flash status block: issues one read and takes
 * the answer.
 * assumes the bench calls read() and that reads never overlap.
 */
`timescale 1ns/1ns
`include "fosr_defs.svh"

module fosr_cpu_model (
	input wire logic clk_i,
	input wire logic rd_valid_i,
	input wire logic [`FOSR_WORD_W-1:0] rd_data_i,
	input wire logic status_sel_i,
	output fosr_pkg::fosr_rd_s rd_o,
	output logic [`FOSR_WORD_W-1:0] array_data_o
);
	initial begin
		rd_o = '0;
		array_data_o = 16'h0000;
	end

	// answer taken one cycle after the request edge
	task automatic read(input logic [`FOSR_ADDR_W-1:0] a,
		input logic [`FOSR_BLK_W-1:0] b,
		input logic [`FOSR_WORD_W-1:0] d,
		output logic [`FOSR_WORD_W-1:0] q,
		output logic v,
		output logic s);
		@(posedge clk_i);
		rd_o <= '{valid: 1'b1, word_addr: a, block: b};
		array_data_o <= d;
		@(posedge clk_i);
		rd_o.valid <= 1'b0;
		array_data_o <= ~d;
		#1;
		q = rd_data_i;
		v = rd_valid_i;
		s = status_sel_i;
	endtask
endmodule // fosr_cpu_model

// File: bench/tb_flash_operation_status_reporting.sv
/*
 * self-checking bench of the flash status block.
 * assumes short window and hold counts set as parameters.
 */
`timescale 1ns/1ns
`include "fosr_defs.svh"

module tb_flash_operation_status_reporting;
	localparam logic [`FOSR_CNT_W-1:0] WIN_C = 14'h0008;
	localparam logic [`FOSR_CNT_W-1:0] HOLD_C = 14'h000A;
	localparam logic [8:0] P_ST = 9'h100, E_ARM = 9'h080, E_PROT = 9'h040;
	localparam logic [8:0] E_DONE = 9'h020, P_DONE = 9'h010, FAIL = 9'h008;
	localparam logic [8:0] SUSP = 9'h004, RES = 9'h002, RRST = 9'h001;
	typedef struct packed {
		logic [17:0] a;
		logic [3:0] b;
		logic [15:0] d;
		logic [15:0] e;
		logic sel;
	} fosr_row_s;
	localparam fosr_row_s ROWS [4] = '{
		{18'h01234, 4'h3, 16'h1111, 16'h0000, 1'b1},
		{18'h00010, 4'h0, 16'h2222, 16'h0000, 1'b1},
		{18'h3FFFF, 4'hF, 16'hFFFF, 16'h0000, 1'b1},
		{18'h01234, 4'h3, 16'h0000, 16'h0000, 1'b1}};
	logic clk_i = 1'b0;
	logic reset_i = 1'b1;
	fosr_pkg::fosr_rd_s rd;
	fosr_pkg::fosr_seq_s seq = '0;
	logic [15:0] arr, rd_data_o, q, last, old_w, new_w;
	logic rd_valid_o, status_sel_o, busy_o, erase_go_o, v, s;
	int fails = 0, compares = 0, cycles = 0, n;

	always #4 clk_i = ~clk_i;
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 3000) begin
			fails++;
			stop_test();
		end
	end

	fosr_status #(.WIN_CYC(WIN_C), .HOLD_CYC(HOLD_C)) DUT (
		.clk_i(clk_i), .reset_i(reset_i), .rd_i(rd), .array_data_i(arr),
		.seq_i(seq), .rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o),
		.status_sel_o(status_sel_o), .busy_o(busy_o),
		.erase_go_o(erase_go_o));
	fosr_cpu_model cpu (
		.clk_i(clk_i), .rd_valid_i(rd_valid_o), .rd_data_i(rd_data_o),
		.status_sel_i(status_sel_o), .rd_o(rd), .array_data_o(arr));

	task automatic stop_test();
		$display("fails=%0d compares=%0d", fails, compares);
		if (fails == 0 && compares > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic chk16(input logic [15:0] g, e, m);
		compares++;
		if ((g & m) !== (e & m)) begin
			fails++;
			$display("Error %0t: word %h want %h", $time, g, e);
		end
	endtask
	task automatic chk1(input logic g, e);
		compares++;
		if (g !== e) begin
			fails++;
			$display("Error %0t: flag %b want %b", $time, g, e);
		end
	endtask
	task automatic ev(input logic [8:0] f);
		@(posedge clk_i);
		seq <= {f, 18'h01234, 4'h3, 4'h5, old_w, new_w};
		@(posedge clk_i);
		seq <= '0;
	endtask
	task automatic rdc(input logic [17:0] a, input logic [3:0] b,
		input logic [15:0] d);
		cpu.read(a, b, d, q, v, s);
	endtask

	initial begin
		old_w = 16'hFFFF;
		new_w = 16'h1280;
		repeat (8) @(posedge clk_i);
		reset_i <= 1'b0;
		@(posedge clk_i);
		#1;
		chk1(busy_o | rd_valid_o | status_sel_o | erase_go_o, 1'b0);
		ev(P_ST);
		foreach (ROWS[i]) begin
			rdc(ROWS[i].a, ROWS[i].b, ROWS[i].d);
			chk1(v & s, ROWS[i].sel);
			chk16(q, ROWS[i].e, 16'hFFB3);
			if (i > 0)
				chk1(q[6], ~last[6]);
			last = q;
		end
		ev(P_DONE);
		rdc(18'h01234, 4'h3, 16'h1280);
		chk1(s, 1'b0);
		chk16(q, 16'h1280, 16'hFFFF);
		old_w = 16'h0000;
		new_w = 16'h0001;
		ev(P_ST);
		rdc(18'h01234, 4'h3, 16'h0000);
		chk16(q, 16'h0020, 16'h0020);
		ev(RRST);
		rdc(18'h01234, 4'h3, 16'h0000);
		chk1(s | busy_o, 1'b0);
		old_w = 16'hFFFF;
		new_w = 16'h1280;
		ev(P_ST);
		ev(FAIL);
		rdc(18'h01234, 4'h3, 16'h0000);
		chk16(q, 16'h0020, 16'h0020);
		rdc(18'h00010, 4'h0, 16'h0000);
		chk16(q, 16'h0020, 16'h0020);
		ev(RRST);
		ev(E_ARM);
		rdc(18'h00000, 4'h5, 16'hFFFF);
		chk16(q, 16'h0000, 16'h0008);
		n = 0;
		while (erase_go_o !== 1'b1 && n < 20) begin
			@(posedge clk_i);
			#1;
			n++;
		end
		chk1(n == int'(WIN_C) - 2, 1'b1);
		rdc(18'h00000, 4'h5, 16'hFFFF);
		chk16(q, 16'h0008, 16'h0088);
		last = q;
		rdc(18'h00000, 4'h5, 16'hFFFF);
		chk1(q[2], ~last[2]);
		ev(SUSP);
		rdc(18'h00000, 4'h5, 16'hFFFF);
		chk16(q, 16'h00C0, 16'h00C0);
		last = q;
		rdc(18'h00010, 4'h0, 16'h5A5A);
		chk1(s, 1'b0);
		chk16(q, 16'h5A5A, 16'hFFFF);
		rdc(18'h00000, 4'h5, 16'hFFFF);
		chk1(q[2], ~last[2]);
		ev(P_ST);
		rdc(18'h01234, 4'h3, 16'h0000);
		chk1(s, 1'b1);
		chk16(q, 16'h0004, 16'h0084);
		ev(P_DONE);
		ev(RES);
		ev(E_DONE);
		rdc(18'h00000, 4'h5, 16'hFFFF);
		chk1(s, 1'b0);
		chk16(q, 16'hFFFF, 16'hFFFF);
		ev(E_ARM);
		repeat (10) @(posedge clk_i);
		ev(FAIL);
		rdc(18'h00000, 4'h5, 16'hFFFF);
		chk16(q, 16'h0020, 16'h00A0);
		last = q;
		rdc(18'h00000, 4'h5, 16'hFFFF);
		chk1(q[2], ~last[2]);
		ev(RRST);
		ev(E_PROT);
		rdc(18'h00000, 4'h5, 16'hFFFF);
		chk16(q, 16'h0000, 16'h0080);
		n = 0;
		while (busy_o !== 1'b0 && n < 30) begin
			@(posedge clk_i);
			#1;
			n++;
		end
		chk1(busy_o, 1'b0);
		rdc(18'h00000, 4'h5, 16'h1234);
		chk16(q, 16'h1234, 16'hFFFF);
		stop_test();
	end
endmodule // tb_flash_operation_status_reporting

// File: design/fosr_defs.svh
/*
 * constants for the flash operation status reporting block: status bit
 * positions, widths and timing counts.
 * assumes a 125 MHz system clock; included by its bare name.
 */
// Function
// - program: poll bit is inverted bit 7
// - erase: poll bit zero, one when done
// - protected erase: poll zero about 100 us
// - entering erase suspend switches poll bit to one
// - program in suspend polls like normal program
// - each status read inverts read toggle bit
// - equal toggle reads mean done; array follows
// - read of suspended block sets read toggle
// - suspend or resume command toggles read toggle
// - failed program or erase sets failure flag
// - programming a zero bit to one fails
// - only read/reset command clears failure flag
// - failure flag zero while successful operation runs
// - erase window flag cleared after last erase command
// - window flag back to one after 96 us
// - reads during erase toggle suspend toggle bit
// - suspended block read or program toggles it
// - suspend program: programmed word reads bit two high
// - failed erase: faulty block reads keep toggling
// - status at programmed word or erased block
// - reads while busy return status bits
`ifndef FOSR_DEFS_SVH
`define FOSR_DEFS_SVH

`define FOSR_CLK_MHZ 125
`define FOSR_WIN_US 96
`define FOSR_HOLD_US 100
`define FOSR_WIN_CYC (`FOSR_WIN_US * `FOSR_CLK_MHZ)
`define FOSR_HOLD_CYC (`FOSR_HOLD_US * `FOSR_CLK_MHZ)
`define FOSR_CNT_W 14

`define FOSR_WORD_W 16
`define FOSR_ADDR_W 18
`define FOSR_BLK_W 4

`define FOSR_POLL_BIT 7
`define FOSR_TOG6_BIT 6
`define FOSR_FAIL_BIT 5
`define FOSR_WIN_BIT 3
`define FOSR_TOG2_BIT 2
`define FOSR_RSVD_MASK 16'hFF13

`endif

// File: design/fosr_pkg.sv
/*
 * types of the flash operation status reporting block.
 * assumes fosr_defs.svh for widths.
 */
`include "fosr_defs.svh"

package fosr_pkg;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_WINDOW,
		ST_ERASE,
		ST_SUSP,
		ST_SUSP_PROG,
		ST_PROG,
		ST_PROT,
		ST_ERR
	} fosr_state_e;

	typedef struct packed {
		logic valid;
		logic [`FOSR_ADDR_W-1:0] word_addr;
		logic [`FOSR_BLK_W-1:0] block;
	} fosr_rd_s;

	typedef struct packed {
		logic prog_start;
		logic erase_arm;
		logic erase_prot;
		logic erase_done;
		logic prog_done;
		logic op_fail;
		logic suspend_cmd;
		logic resume_cmd;
		logic read_reset;
		logic [`FOSR_ADDR_W-1:0] prog_addr;
		logic [`FOSR_BLK_W-1:0] prog_block;
		logic [`FOSR_BLK_W-1:0] erase_block;
		logic [`FOSR_WORD_W-1:0] old_word;
		logic [`FOSR_WORD_W-1:0] new_word;
	} fosr_seq_s;

endpackage

// File: design/fosr_status.sv
/*
 * status reporting of the erase/program engine: tracks the operation in
 * progress and answers cpu flash reads with the five status bits, or with array data when idle or off both the suspended block and the programmed word.
 * assumes the command sequencer gives one-cycle event pulses and the
 * array supplies read data in the cycle of the read.
 */
`timescale 1ns/1ns
`include "fosr_defs.svh"

module fosr_status #(
	parameter logic [`FOSR_CNT_W-1:0] WIN_CYC = `FOSR_CNT_W'(`FOSR_WIN_CYC),
	parameter logic [`FOSR_CNT_W-1:0] HOLD_CYC = `FOSR_CNT_W'(`FOSR_HOLD_CYC)
) (
	input wire logic clk_i,
	input wire logic reset_i,
	input wire fosr_pkg::fosr_rd_s rd_i,
	input wire logic [`FOSR_WORD_W-1:0] array_data_i,
	input wire fosr_pkg::fosr_seq_s seq_i,
	output logic [`FOSR_WORD_W-1:0] rd_data_o,
	output logic rd_valid_o,
	output logic status_sel_o,
	output logic busy_o,
	output logic erase_go_o
);

	fosr_pkg::fosr_state_e state_ff;
	fosr_pkg::fosr_state_e nxt_state;
	logic fail_ff;
	logic nxt_fail;
	logic tog6_ff;
	logic nxt_tog6;
	logic tog2_ff;
	logic nxt_tog2;
	logic bit7_ff;
	logic err_erase_ff;
	logic [`FOSR_ADDR_W-1:0] prog_addr_ff;
	logic [`FOSR_BLK_W-1:0] erase_blk_ff;
	logic [`FOSR_WORD_W-1:0] nxt_rd_data;
	logic [`FOSR_WORD_W-1:0] status_word;
	logic load_win;
	logic load_hold;
	logic tmr_expire;
	logic erase_go;

	// decode of the current operation
	wire in_idle = state_ff == fosr_pkg::ST_IDLE;
	wire in_window = state_ff == fosr_pkg::ST_WINDOW;
	wire in_erase = state_ff == fosr_pkg::ST_ERASE;
	wire in_susp = state_ff == fosr_pkg::ST_SUSP;
	wire in_sprog = state_ff == fosr_pkg::ST_SUSP_PROG;
	wire in_prog = state_ff == fosr_pkg::ST_PROG;
	wire in_err = state_ff == fosr_pkg::ST_ERR;
	wire any_susp = in_susp | in_sprog;

	// program accepted only from read mode or from erase suspend
	wire prog_ok = seq_i.prog_start & (in_idle | in_susp);
	wire bit_up = |(~seq_i.old_word & seq_i.new_word);
	wire arm_ok = seq_i.erase_arm & in_idle;
	wire prot_ok = seq_i.erase_prot & in_idle;

	// address matching
	wire blk_hit = rd_i.block == erase_blk_ff;
	wire word_hit = rd_i.word_addr == prog_addr_ff;
	wire susp_blk_rd = rd_i.valid & any_susp & blk_hit;
	wire sprog_word_rd = in_sprog & word_hit;
	wire fault_rd = rd_i.valid & in_err & err_erase_ff & blk_hit;
	wire prog_into_susp = prog_ok & in_susp &
		(seq_i.prog_block == erase_blk_ff);

	// status selection: suspend lets other blocks read the array
	wire sel_busy = ~in_idle & ~any_susp;
	wire sel_susp = in_susp & blk_hit;
	wire sel_sprog = in_sprog & (blk_hit | word_hit);
	wire stat_sel = sel_busy | sel_susp | sel_sprog;
	wire stat_rd = rd_i.valid & stat_sel;

	// command events that flip the read toggle bit
	wire cmd_tog = (in_erase & seq_i.suspend_cmd) |
		(in_susp & seq_i.resume_cmd);

	// completion poll bit per operation
	wire poll_bit = (in_prog | in_sprog) ? ~bit7_ff :
		in_susp;
	wire tog6_bit = susp_blk_rd | tog6_ff;
	wire win_bit = ~in_window;
	wire tog2_bit = sprog_word_rd | tog2_ff;
	wire tog2_flip = (stat_rd & (in_window | in_erase)) |
		(susp_blk_rd & ~sprog_word_rd) | prog_into_susp |
		fault_rd;

	always_comb begin
		status_word = '0;
		status_word[`FOSR_POLL_BIT] = poll_bit;
		status_word[`FOSR_TOG6_BIT] = tog6_bit;
		status_word[`FOSR_FAIL_BIT] = fail_ff;
		status_word[`FOSR_WIN_BIT] = win_bit;
		status_word[`FOSR_TOG2_BIT] = tog2_bit;
	end

	// array data in read mode and for reads outside the suspended block or programmed word
	assign nxt_rd_data = stat_sel ? status_word : array_data_i;

	// failure flag: a new failure wins over read/reset
	assign nxt_fail = seq_i.op_fail | (prog_ok & bit_up) |
		(fail_ff & ~seq_i.read_reset);

	assign nxt_tog6 = (stat_rd & susp_blk_rd) ? 1'b1 :
		tog6_ff ^ (stat_rd ^ cmd_tog);
	assign nxt_tog2 = tog2_ff ^ tog2_flip;

	always_comb begin
		nxt_state = state_ff;
		load_win = 1'b0;
		load_hold = 1'b0;
		erase_go = 1'b0;
		unique case (state_ff)
			fosr_pkg::ST_IDLE: begin
				if (prog_ok) begin
					nxt_state = bit_up ? fosr_pkg::ST_ERR :
						fosr_pkg::ST_PROG;
				end else if (prot_ok) begin
					nxt_state = fosr_pkg::ST_PROT;
					load_hold = 1'b1;
				end else if (arm_ok) begin
					nxt_state = fosr_pkg::ST_WINDOW;
					load_win = 1'b1;
				end
			end
			fosr_pkg::ST_WINDOW: begin
				if (tmr_expire) begin
					nxt_state = fosr_pkg::ST_ERASE;
					erase_go = 1'b1;
				end
			end
			fosr_pkg::ST_ERASE: begin
				if (seq_i.op_fail) begin
					nxt_state = fosr_pkg::ST_ERR;
				end else if (seq_i.erase_done) begin
					nxt_state = fosr_pkg::ST_IDLE;
				end else if (seq_i.suspend_cmd) begin
					nxt_state = fosr_pkg::ST_SUSP;
				end
			end
			fosr_pkg::ST_SUSP: begin
				if (seq_i.resume_cmd) begin
					nxt_state = fosr_pkg::ST_ERASE;
				end else if (prog_ok) begin
					nxt_state = fosr_pkg::ST_SUSP_PROG;
				end
			end
			fosr_pkg::ST_SUSP_PROG: begin
				if (seq_i.prog_done | seq_i.op_fail) begin
					nxt_state = fosr_pkg::ST_SUSP;
				end
			end
			fosr_pkg::ST_PROG: begin
				if (seq_i.op_fail) begin
					nxt_state = fosr_pkg::ST_ERR;
				end else if (seq_i.prog_done) begin
					nxt_state = fosr_pkg::ST_IDLE;
				end
			end
			fosr_pkg::ST_PROT: begin
				if (tmr_expire) begin
					nxt_state = fosr_pkg::ST_IDLE;
				end
			end
			fosr_pkg::ST_ERR: begin
				if (seq_i.read_reset) begin
					nxt_state = fosr_pkg::ST_IDLE;
				end
			end
		endcase
	end

	fosr_timer u_timer (
		.clk_i(clk_i),
		.reset_i(reset_i),
		.load_i(load_win | load_hold),
		.value_i(load_win ? WIN_CYC : HOLD_CYC),
		.expire_o(tmr_expire)
	);

	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			state_ff <= fosr_pkg::ST_IDLE;
			fail_ff <= 1'b0;
			tog6_ff <= 1'b0;
			tog2_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			fail_ff <= nxt_fail;
			tog6_ff <= nxt_tog6;
			tog2_ff <= nxt_tog2;
		end
	end

	// operation context captured when an operation is accepted
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			bit7_ff <= 1'b0;
			prog_addr_ff <= '0;
			erase_blk_ff <= '0;
			err_erase_ff <= 1'b0;
		end else begin
			if (prog_ok) begin
				bit7_ff <= seq_i.new_word[`FOSR_POLL_BIT];
				prog_addr_ff <= seq_i.prog_addr;
			end
			if (arm_ok) begin
				erase_blk_ff <= seq_i.erase_block;
			end
			if (in_erase & seq_i.op_fail) begin
				err_erase_ff <= 1'b1;
			end else if (in_idle) begin
				err_erase_ff <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			rd_data_o <= '0;
			rd_valid_o <= 1'b0;
			status_sel_o <= 1'b0;
			busy_o <= 1'b0;
			erase_go_o <= 1'b0;
		end else begin
			rd_data_o <= rd_i.valid ? nxt_rd_data : rd_data_o;
			rd_valid_o <= rd_i.valid;
			status_sel_o <= stat_rd;
			busy_o <= nxt_state != fosr_pkg::ST_IDLE;
			erase_go_o <= erase_go;
		end
	end

	property p_prog_poll;
		@(posedge clk_i) disable iff (reset_i)
		(rd_i.valid && in_prog) |=> rd_data_o[`FOSR_POLL_BIT] == ~bit7_ff;
	endproperty
	a_prog_poll: assert property (p_prog_poll)
		else $error("poll bit not inverted bit 7 during program");

	property p_erase_poll;
		@(posedge clk_i) disable iff (reset_i)
		(rd_i.valid && (in_erase || in_window)) |=>
			!rd_data_o[`FOSR_POLL_BIT] && status_sel_o;
	endproperty
	a_erase_poll: assert property (p_erase_poll)
		else $error("poll bit not zero during erase");

	property p_susp_read;
		@(posedge clk_i) disable iff (reset_i)
		(in_susp && rd_i.valid && blk_hit) |=>
			rd_data_o[`FOSR_POLL_BIT] && rd_data_o[`FOSR_TOG6_BIT];
	endproperty
	a_susp_read: assert property (p_susp_read)
		else $error("suspended block read lacks poll or toggle one");

	property p_tog6_flip;
		@(posedge clk_i) disable iff (reset_i)
		(rd_i.valid && in_prog) ##1 (!rd_i.valid && in_prog) ##1
			(rd_i.valid && in_prog) |=>
			rd_data_o[`FOSR_TOG6_BIT] !=
			$past(rd_data_o[`FOSR_TOG6_BIT], 2);
	endproperty
	a_tog6_flip: assert property (p_tog6_flip)
		else $error("read toggle bit did not flip between reads");

	property p_fail_set;
		@(posedge clk_i) disable iff (reset_i)
		seq_i.op_fail |=> fail_ff;
	endproperty
	a_fail_set: assert property (p_fail_set)
		else $error("failure flag not set after failed operation");

	property p_fail_hold;
		@(posedge clk_i) disable iff (reset_i)
		(fail_ff && !seq_i.read_reset) |=> fail_ff;
	endproperty
	a_fail_hold: assert property (p_fail_hold)
		else $error("failure flag cleared without read/reset");

	property p_win_flag;
		@(posedge clk_i) disable iff (reset_i)
		arm_ok |=> in_window ##0 (!erase_go_o)[*2];
	endproperty
	a_win_flag: assert property (p_win_flag)
		else $error("erase window not entered after last erase command");

	// cycles since the last erase command, for the window length checks
	logic [`FOSR_CNT_W:0] win_age_ff;
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			win_age_ff <= '0;
		end else if (arm_ok) begin
			win_age_ff <= {{`FOSR_CNT_W{1'b0}}, 1'b1};
		end else if (in_window) begin
			win_age_ff <= win_age_ff + 1'b1;
		end
	end

	property p_win_len;
		@(posedge clk_i) disable iff (reset_i)
		erase_go_o |-> win_age_ff == {1'b0, WIN_CYC} + 1'b1;
	endproperty
	a_win_len: assert property (p_win_len)
		else $error("erase did not start after the acceptance window");

	property p_win_max;
		@(posedge clk_i) disable iff (reset_i)
		in_window |-> win_age_ff <= {1'b0, WIN_CYC};
	endproperty
	a_win_max: assert property (p_win_max)
		else $error("erase window outlasted its time-out");

	property p_cmd_tog;
		@(posedge clk_i) disable iff (reset_i)
		(((in_erase && seq_i.suspend_cmd) || (in_susp && seq_i.resume_cmd))
			&& !rd_i.valid) |=> tog6_ff != $past(tog6_ff);
	endproperty
	a_cmd_tog: assert property (p_cmd_tog)
		else $error("read toggle bit did not flip on suspend or resume");

	property p_reserved;
		@(posedge clk_i) disable iff (reset_i)
		(rd_valid_o && status_sel_o) |->
			(rd_data_o & `FOSR_RSVD_MASK) == '0;
	endproperty
	a_reserved: assert property (p_reserved)
		else $error("reserved status bits not zero");

endmodule // fosr_status

// File: design/fosr_timer.sv
/*
 * down counter for the erase window and protected-erase hold times.
 * assumes load_i is a one-cycle pulse; expire_o pulses once per load.
 */
`timescale 1ns/1ns
`include "fosr_defs.svh"

module fosr_timer (
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic load_i,
	input wire logic [`FOSR_CNT_W-1:0] value_i,
	output logic expire_o
);

	logic [`FOSR_CNT_W-1:0] count_ff;
	logic [`FOSR_CNT_W-1:0] nxt_count;
	logic running;

	assign running = count_ff != '0;
	assign expire_o = count_ff == `FOSR_CNT_W'(1);
	assign nxt_count = load_i ? value_i :
		running ? count_ff - `FOSR_CNT_W'(1) : count_ff;

	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			count_ff <= '0;
		end else begin
			count_ff <= nxt_count;
		end
	end

endmodule // fosr_timer
